// >>> rtl/line_alarm_pkg.sv
/*
 line_alarm_pkg: constants, modes and carrier structs for the three-channel
 control and alarm logic. assumes one 10 MHz system clock and that all pin
 inputs, including the per-channel clock levels, arrive synchronous to it.
*/
package line_alarm_pkg;
   localparam int NUM_CH = 3;
   localparam int CLK_MHZ = 10;
   localparam logic [7:0] DRIVE_IDLE_PERIODS = 8'h80;
   // ppm of deviation that trips loss of lock (0.5 %)
   localparam int LOCK_TOL_PPM = 5000;
   // reference clock periods per lock measurement window
   localparam int LOCK_WIN = 1024;
   localparam logic [11:0] LOCK_WIN_CNT = 12'(LOCK_WIN);
   localparam logic [11:0] LOCK_TOL_CNT = 12'((LOCK_WIN * LOCK_TOL_PPM) / 1000000);
   // consecutive zero receive bits declaring loss of signal
   localparam logic [7:0] LOS_ZEROS_E3 = 8'h20;
   localparam logic [7:0] LOS_ZEROS_LO = 8'h64;
   localparam logic [7:0] LOS_ZEROS_HI = 8'hc8;

   typedef enum logic [1:0] {
      LOOP_NONE    = 2'b00,
      LOOP_REMOTE  = 2'b01,
      LOOP_ANALOG  = 2'b10,
      LOOP_DIGITAL = 2'b11
   } loop_mode_t;

   typedef struct packed {
      logic tip;
      logic ring;
   } rail_pair_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } rx_data_t;
endpackage

// >>> rtl/line_channel.sv
/*
 line_channel: one channel's drive monitor, loss-of-signal, loss-of-lock,
 code violation, all-ones and loop-back selection. clock inputs are levels
 sampled on i_clk, so each link clock must run well below 5 MHz here.
*/
`timescale 1ns/100ps
module line_channel
   import line_alarm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_host_select,
   input wire logic i_e3_mode,
   input wire logic i_tx_clock,
   input wire logic i_rx_recovered_clock,
   input wire logic i_ref_clock,
   input wire rail_pair_t i_monitor,
   input wire rail_pair_t i_tx_data,
   input wire rx_data_t i_rx_line,
   input wire logic i_tx_all_ones_sel,
   input wire logic i_local_loop_sel,
   input wire logic i_remote_loop_sel,
   input wire logic i_signal_loss_threshold_sel,
   input wire logic i_mute_on_loss_en,
   output rail_pair_t o_tx_line,
   output rx_data_t o_rx_data,
   output loop_mode_t o_loop_mode,
   output logic o_drive_fail_flag,
   output logic o_rx_signal_loss_out,
   output logic o_rx_lock_loss_out,
   output logic o_code_violation_out
);
   logic tx_clk_d_r, rx_clk_d_r, ref_clk_d_r;
   logic tx_rise, rx_rise, ref_rise;
   logic [7:0] idle_cnt_r;
   logic [7:0] zero_cnt_r;
   logic [7:0] los_limit;
   logic [11:0] ref_cnt_r, rec_cnt_r;
   logic last_pol_r, ones_pol_r, mark_seen_r;
   logic hw_mode;
   logic violation;

   assign hw_mode = ~i_host_select;
   assign tx_rise = i_tx_clock & ~tx_clk_d_r;
   assign rx_rise = i_rx_recovered_clock & ~rx_clk_d_r;
   assign ref_rise = i_ref_clock & ~ref_clk_d_r;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_clk_d_r <= 1'b0;
         rx_clk_d_r <= 1'b0;
         ref_clk_d_r <= 1'b0;
      end else begin
         tx_clk_d_r <= i_tx_clock;
         rx_clk_d_r <= i_rx_recovered_clock;
         ref_clk_d_r <= i_ref_clock;
      end
   end

   // drive monitor: counts tx clock periods with no pulse on either monitor rail
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         idle_cnt_r <= 8'h00;
         o_drive_fail_flag <= 1'b0;
      end else if (i_monitor.tip | i_monitor.ring) begin
         idle_cnt_r <= 8'h00;
         o_drive_fail_flag <= 1'b0;
      end else if (tx_rise) begin
         if (idle_cnt_r == DRIVE_IDLE_PERIODS - 8'h01) begin
            o_drive_fail_flag <= 1'b1;
         end else begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
         end
      end
   end

   // loss of signal: run of zero receive bits, length set by mode and threshold
   always_comb begin
      if (i_e3_mode) begin
         los_limit = LOS_ZEROS_E3;
      end else if (i_signal_loss_threshold_sel) begin
         los_limit = LOS_ZEROS_HI;
      end else begin
         los_limit = LOS_ZEROS_LO;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         zero_cnt_r <= 8'h00;
         o_rx_signal_loss_out <= 1'b0;
      end else if (rx_rise) begin
         if (i_rx_line.pos | i_rx_line.neg) begin
            zero_cnt_r <= 8'h00;
            o_rx_signal_loss_out <= 1'b0;
         end else if (zero_cnt_r >= los_limit - 8'h01) begin
            o_rx_signal_loss_out <= 1'b1;
         end else begin
            zero_cnt_r <= zero_cnt_r + 8'h01;
         end
      end
   end

   // loss of lock: count recovered edges over a fixed reference window
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ref_cnt_r <= 12'h000;
         rec_cnt_r <= 12'h000;
         o_rx_lock_loss_out <= 1'b0;
      end else if (ref_rise && ref_cnt_r == LOCK_WIN_CNT - 12'h001) begin
         ref_cnt_r <= 12'h000;
         rec_cnt_r <= 12'h000;
         o_rx_lock_loss_out <= (rec_cnt_r > LOCK_WIN_CNT + LOCK_TOL_CNT) ||
                               (rec_cnt_r < LOCK_WIN_CNT - LOCK_TOL_CNT);
      end else begin
         if (ref_rise) begin
            ref_cnt_r <= ref_cnt_r + 12'h001;
         end
         if (rx_rise && rec_cnt_r != '1) begin
            rec_cnt_r <= rec_cnt_r + 12'h001;
         end
      end
   end

   // bipolar violation: two marks of the same polarity in a row
   // first mark after reset has no known predecessor, so it is never flagged
   assign violation = mark_seen_r &
                      ((i_rx_line.pos & last_pol_r) | (i_rx_line.neg & ~last_pol_r));

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         last_pol_r <= 1'b0;
         mark_seen_r <= 1'b0;
         o_code_violation_out <= 1'b0;
      end else if (rx_rise) begin
         o_code_violation_out <= violation & ~(i_rx_line.pos & i_rx_line.neg);
         if (i_rx_line.pos ^ i_rx_line.neg) begin
            last_pol_r <= i_rx_line.pos;
            mark_seen_r <= 1'b1;
         end
      end
   end

   // recovered data, muted in hardware mode while loss of signal is declared
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rx_data <= '0;
      end else if (hw_mode && i_mute_on_loss_en && o_rx_signal_loss_out) begin
         o_rx_data <= '0;
      end else if (rx_rise) begin
         o_rx_data <= i_rx_line;
      end
   end

   // transmit: all-ones alternates polarity once per tx clock period
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ones_pol_r <= 1'b0;
         o_tx_line <= '0;
      end else if (tx_rise) begin
         if (hw_mode && i_tx_all_ones_sel) begin
            ones_pol_r <= ~ones_pol_r;
            o_tx_line.tip <= ~ones_pol_r;
            o_tx_line.ring <= ones_pol_r;
         end else begin
            o_tx_line <= i_tx_data;
         end
      end
   end

   // loop-back selection is ignored in host mode
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_loop_mode <= LOOP_NONE;
      end else if (!hw_mode) begin
         o_loop_mode <= LOOP_NONE;
      end else begin
         case ({i_local_loop_sel, i_remote_loop_sel})
            2'b10: o_loop_mode <= LOOP_ANALOG;
            2'b11: o_loop_mode <= LOOP_DIGITAL;
            2'b01: o_loop_mode <= LOOP_REMOTE;
            default: o_loop_mode <= LOOP_NONE;
         endcase
      end
   end
endmodule // line_channel

// >>> rtl/line_alarm_loopback_control.sv
/*
 line_alarm_loopback_control: three channels of control and alarm pin logic
 with the global mute, host select and in-circuit-test controls. assumes the
 pad ring resolves each output from its enable; enables are high to drive.
*/
`timescale 1ns/100ps
module line_alarm_loopback_control
   import line_alarm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_host_select,
   input wire logic i_incircuit_test_n,
   input wire logic i_mute_on_loss_en,
   input wire logic [NUM_CH-1:0] i_e3_mode,
   input wire logic [NUM_CH-1:0] i_tx_clock,
   input wire logic [NUM_CH-1:0] i_rx_recovered_clock,
   input wire logic [NUM_CH-1:0] i_ref_clock,
   input wire logic [NUM_CH-1:0] i_monitor_tip_in,
   input wire logic [NUM_CH-1:0] i_monitor_ring_in,
   input wire rail_pair_t [NUM_CH-1:0] i_tx_data,
   input wire rx_data_t [NUM_CH-1:0] i_rx_line,
   input wire logic [NUM_CH-1:0] i_tx_all_ones_sel,
   input wire logic [NUM_CH-1:0] i_local_loop_sel,
   input wire logic [NUM_CH-1:0] i_remote_loop_sel,
   input wire logic [NUM_CH-1:0] i_signal_loss_threshold_sel,
   output rail_pair_t [NUM_CH-1:0] o_tx_line,
   output rx_data_t [NUM_CH-1:0] o_rx_data,
   output loop_mode_t [NUM_CH-1:0] o_loop_mode,
   output logic [NUM_CH-1:0] o_drive_fail_flag,
   output logic [NUM_CH-1:0] o_rx_signal_loss_out,
   output logic [NUM_CH-1:0] o_rx_lock_loss_out,
   output logic [NUM_CH-1:0] o_code_violation_out,
   output logic o_output_en
);
   // a single enable: every output pad floats together for board test
   assign o_output_en = i_incircuit_test_n;

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      rail_pair_t mon;
      assign mon.tip = i_monitor_tip_in[ch];
      assign mon.ring = i_monitor_ring_in[ch];
      line_channel u_ch (
         .i_clk(i_clk),
         .i_resetn(i_resetn),
         .i_host_select(i_host_select),
         .i_e3_mode(i_e3_mode[ch]),
         .i_tx_clock(i_tx_clock[ch]),
         .i_rx_recovered_clock(i_rx_recovered_clock[ch]),
         .i_ref_clock(i_ref_clock[ch]),
         .i_monitor(mon),
         .i_tx_data(i_tx_data[ch]),
         .i_rx_line(i_rx_line[ch]),
         .i_tx_all_ones_sel(i_tx_all_ones_sel[ch]),
         .i_local_loop_sel(i_local_loop_sel[ch]),
         .i_remote_loop_sel(i_remote_loop_sel[ch]),
         .i_signal_loss_threshold_sel(i_signal_loss_threshold_sel[ch]),
         .i_mute_on_loss_en(i_mute_on_loss_en),
         .o_tx_line(o_tx_line[ch]),
         .o_rx_data(o_rx_data[ch]),
         .o_loop_mode(o_loop_mode[ch]),
         .o_drive_fail_flag(o_drive_fail_flag[ch]),
         .o_rx_signal_loss_out(o_rx_signal_loss_out[ch]),
         .o_rx_lock_loss_out(o_rx_lock_loss_out[ch]),
         .o_code_violation_out(o_code_violation_out[ch])
      );
   end
endmodule // line_alarm_loopback_control

// >>> verification/terminal_clock_model.sv
/*
 terminal_clock_model: terminal-side clock sources for three channels (tx, recovered rx, ref).
 assumes one system clock; levels step on it, at least two cycles apart.
*/
`timescale 1ns/100ps
module terminal_clock_model (
   input wire logic i_clk,
   input wire logic [3:0] i_ref_half,
   output logic [2:0] o_tx_clock,
   output logic [2:0] o_rx_clock,
   output logic [2:0] o_ref_clock
);
   logic [7:0] cnt_r = '0;
   logic [3:0] ref_cnt_r = '0;
   logic ref_r = 1'b0;
   // line clocks run free, as a real line does
   always @(posedge i_clk) begin
      cnt_r <= cnt_r + 8'h01;
   end
   // ref half period is adjustable so lock can be broken on purpose
   always @(posedge i_clk) begin
      ref_cnt_r <= (ref_cnt_r >= i_ref_half - 4'h1) ? 4'h0 : ref_cnt_r + 4'h1;
      if (ref_cnt_r >= i_ref_half - 4'h1) begin
         ref_r <= ~ref_r;
      end
   end
   assign o_tx_clock = {3{cnt_r[1]}};
   assign o_rx_clock = {3{cnt_r[2]}};
   assign o_ref_clock = {3{ref_r}};
endmodule // terminal_clock_model

// >>> verification/line_alarm_loopback_control_sva.sv
/*
 line_alarm_sva: port checks on channel 0 and the global controls.
 assumes only the top module's ports; bound below.
*/
`timescale 1ns/100ps
module line_alarm_sva
   import line_alarm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_host_select,
   input wire logic i_incircuit_test_n,
   input wire logic i_mute_on_loss_en,
   input wire logic [NUM_CH-1:0] i_monitor_tip_in,
   input wire logic [NUM_CH-1:0] i_monitor_ring_in,
   input wire rx_data_t [NUM_CH-1:0] i_rx_line,
   input wire logic [NUM_CH-1:0] i_local_loop_sel,
   input wire logic [NUM_CH-1:0] i_remote_loop_sel,
   input wire rx_data_t [NUM_CH-1:0] o_rx_data,
   input wire loop_mode_t [NUM_CH-1:0] o_loop_mode,
   input wire logic [NUM_CH-1:0] o_drive_fail_flag,
   input wire logic [NUM_CH-1:0] o_rx_signal_loss_out,
   input wire logic [NUM_CH-1:0] o_code_violation_out,
   input wire logic o_output_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   a_oe_follow: assert property (o_output_en == i_incircuit_test_n)
      else $error("output enable mismatch");
   a_reset_zero: assert property ($rose(i_resetn) |->
      !o_drive_fail_flag && !o_rx_signal_loss_out) else $error("flags not clear after reset");
   a_loop_host: assert property (i_host_select |=> o_loop_mode[0] == LOOP_NONE)
      else $error("loop mode set in host mode");
   a_loop_map: assert property (!i_host_select |=>
      o_loop_mode[0] == {$past(i_local_loop_sel[0]), $past(i_remote_loop_sel[0])})
      else $error("loop mode decode wrong");
   a_mute_data: assert property (
      (!i_host_select && i_mute_on_loss_en && o_rx_signal_loss_out[0])[*2]
      |-> o_rx_data[0] == 2'b00) else $error("data not muted");
   a_drive_clear: assert property (o_drive_fail_flag[0] &&
      (i_monitor_tip_in[0] || i_monitor_ring_in[0]) |=> !o_drive_fail_flag[0])
      else $error("drive flag stuck");
   a_drive_rise: assert property ($rose(o_drive_fail_flag[0]) |->
      !$past(i_monitor_tip_in[0] || i_monitor_ring_in[0])) else $error("drive flag on activity");
   a_lcv_mark: assert property ($rose(o_code_violation_out[0]) |->
      $past(i_rx_line[0]) inside {2'b01, 2'b10}) else $error("violation without mark");
endmodule // line_alarm_sva
bind line_alarm_loopback_control line_alarm_sva chk_u (.i_clk, .i_resetn, .i_host_select,
   .i_incircuit_test_n, .i_mute_on_loss_en, .i_monitor_tip_in, .i_monitor_ring_in, .i_rx_line,
   .i_local_loop_sel, .i_remote_loop_sel, .o_rx_data, .o_loop_mode, .o_drive_fail_flag,
   .o_rx_signal_loss_out, .o_code_violation_out, .o_output_en);

// >>> verification/line_alarm_loopback_control_test.sv
/*
 line_alarm_loopback_control_test: self-checking bench for the three channels.
 assumes terminal_clock_model supplies the link clocks; all channels get the same driven stimulus, with per-channel e3 and threshold selects.
*/
`timescale 1ns/100ps
module line_alarm_loopback_control_test;
   import line_alarm_pkg::*;
   typedef struct packed {logic host; logic loc; logic rem; loop_mode_t mode;} loop_row_t;
   loop_row_t rows [5] = '{'{1'b1, 1'b1, 1'b1, LOOP_NONE}, '{1'b0, 1'b1, 1'b0, LOOP_ANALOG},
      '{1'b0, 1'b1, 1'b1, LOOP_DIGITAL}, '{1'b0, 1'b0, 1'b1, LOOP_REMOTE},
      '{1'b0, 1'b0, 1'b0, LOOP_NONE}};
   logic i_clk = 1'b0, i_resetn = 1'b0, host = 1'b0, ict_n = 1'b1, mute = 1'b0, oe;
   logic [2:0] mon_tip = '0, mon_ring = '0, aos = '0, lloop = '0, rloop = '0;
   logic [2:0] tx_c, rx_c, ref_c, dfail, los, lol, lcv;
   logic [3:0] ref_half = 4'h4;
   rail_pair_t [2:0] tx_data = '0, tx_line;
   rx_data_t [2:0] rx_line = '0, rx_data;
   loop_mode_t [2:0] mode;
   int err_total = 0, checks = 0, n, m;
   always #50 i_clk = ~i_clk;
   terminal_clock_model far_u (.i_clk(i_clk), .i_ref_half(ref_half), .o_tx_clock(tx_c),
      .o_rx_clock(rx_c), .o_ref_clock(ref_c));
   // threshold select stays static from power-up, as the line side demands;
   // channel 1 uses the high threshold, channel 2 runs e3 where the select must be ignored
   line_alarm_loopback_control dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_host_select(host),
      .i_incircuit_test_n(ict_n), .i_mute_on_loss_en(mute), .i_e3_mode(3'h4), .i_tx_clock(tx_c),
      .i_rx_recovered_clock(rx_c), .i_ref_clock(ref_c), .i_monitor_tip_in(mon_tip),
      .i_monitor_ring_in(mon_ring), .i_tx_data(tx_data), .i_rx_line(rx_line),
      .i_tx_all_ones_sel(aos), .i_local_loop_sel(lloop), .i_remote_loop_sel(rloop),
      .i_signal_loss_threshold_sel(3'h6), .o_tx_line(tx_line), .o_rx_data(rx_data),
      .o_loop_mode(mode), .o_drive_fail_flag(dfail), .o_rx_signal_loss_out(los),
      .o_rx_lock_loss_out(lol), .o_code_violation_out(lcv), .o_output_en(oe));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask
   // data changes on the falling rx level; violations are read once per rx period
   task automatic send(input rx_data_t v, input int cnt);
      for (int k = 0; k < cnt; k++) begin
         @(posedge i_clk);
         while (rx_c[0] !== 1'b1) @(posedge i_clk);
         while (rx_c[0] !== 1'b0) @(posedge i_clk);
         if (lcv[0] === 1'b1) n++;
         rx_line <= {3{v}};
      end
   endtask
   task automatic count_tx();
      rail_pair_t p;
      p = tx_line[0];
      n = 0;
      m = 0;
      repeat (80) begin
         @(posedge i_clk);
         if (tx_line[0].tip && !p.tip) n++;
         if (tx_line[0].ring && !p.ring) m++;
         p = tx_line[0];
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge i_clk);
      err_total++;
      finish_test();
   end
   initial begin
      tick(16);
      i_resetn <= 1'b1;
      tick(1);
      #1 chk(16'({dfail, los, lol, lcv}), 16'h0);
      foreach (rows[r]) begin
         tick(1);
         host <= rows[r].host;
         lloop <= {3{rows[r].loc}};
         rloop <= {3{rows[r].rem}};
         tick(2);
         #1 chk(16'(mode), 16'({3{rows[r].mode}}));
      end
      tick(1);
      lloop <= 3'h7;
      rloop <= 3'h7;
      tick(2);
      ict_n <= 1'b0; // pads float one cycle before reset, so the enable is seen outside reset
      tick(1);
      i_resetn <= 1'b0;
      #1 chk(16'({mode, oe}), 16'h0);
      tick(2);
      i_resetn <= 1'b1;
      ict_n <= 1'b1;
      lloop <= 3'h0;
      rloop <= 3'h0;
      mon_tip <= 3'h7;
      tick(2);
      mon_tip <= 3'h0;
      tick(4 * 95);
      #1 chk(16'(dfail), 16'h0);
      tick(4 * 66);
      #1 chk(16'(dfail), 16'h7);
      tick(1);
      mon_ring <= 3'h7;
      tick(2);
      #1 chk(16'(dfail), 16'h0);
      tick(1);
      mon_ring <= 3'h0;
      aos <= 3'h7;
      count_tx();
      chk(16'(n >= 9 && m >= 9), 16'h1);
      host <= 1'b1;
      tick(4);
      count_tx();
      chk(16'(n + m), 16'h0);
      host <= 1'b0;
      aos <= 3'h0;
      mute <= 1'b1;
      send(2'b00, 230);
      #1 chk(16'({los, rx_data}), 16'h1c0);
      send(2'b10, 1);
      send(2'b01, 1);
      n = 0;
      send(2'b10, 1);
      send(2'b01, 1);
      send(2'b00, 2);
      #1 chk(16'({los, 4'(n)}), 16'h0);
      send(2'b01, 1);
      send(2'b00, 2);
      chk(16'(n), 16'h1);
      send(2'b00, 38);
      #1 chk(16'(los), 16'h4);
      send(2'b00, 80);
      #1 chk(16'(los), 16'h5);
      send(2'b00, 100);
      #1 chk(16'(los), 16'h7);
      tick(16500);
      #1 chk(16'(lol), 16'h0);
      tick(1);
      ref_half <= 4'h3;
      tick(12500);
      #1 chk(16'(lol), 16'h7);
      finish_test();
   end
endmodule // line_alarm_loopback_control_test
